// >>> verilog/mcu_reset_sequencer.sv
// Purpose: merges reset sources, forces initial state, times release
// Assumes: wdt_overflow_i comes from logic on clk_i
// Notes:   build options are module parameters
// Overview of operation
// - any of power-on, pin, key combination or watchdog enters reset.
// - program counter is forced to address zero while in reset.
// - control flags clear to zero in reset, backup flag set to one.
// - both sounder outputs and both panel outputs held low in reset.
// - pull-low on all five ports switched on, all ports input.
// - debounce stage ten, pump base quarter, clear stage eight quarter.
// - frequency generator base clock, quarter duty, stopped.
// - converter stopped, its six outputs low.
// - display all off, key scanner stopped, sixteen scan outputs high.
// - timers stopped; watchdog stopped and its enable flag cleared, except on watchdog reset.
// - system clock source set to slow crystal.
// - after a source, count interval, then resume normal operation.
// - interval is 16384 or 2048 base clock cycles by option.
// - power-on detection acts only when enabled, then starts count.
// - low reset pin places device in reset.
// - reset pin handled as level or pulse by option.
// - level mode holds counter idle while pin low, counts after high.
// - pulse mode counts at once and finishes whatever the pin does.
// - all selected port inputs, or all selected scan inputs, high together enter reset.
// - key combination count begins once any selected input falls.
// - watchdog reset keeps watchdog running, flag set, divider uncleared.
// - other sources disable watchdog and clear its flag.
`timescale 1ns/10ps
`default_nettype none
module mcu_reset_sequencer #(
  parameter bit         POR_EN        = 1'b1,
  parameter bit         PIN_PULSE     = 1'b0,
  parameter bit         SHORT_SEL     = 1'b0,
  parameter logic [3:0] KEY_PORT_MASK = 4'h0,
  parameter logic [3:0] KEY_SCAN_MASK = 4'hF,
  parameter int         LONG_CYCLES   = reset_seq_pkg::LONG_CYCLES_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        por_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic [3:0]  key_port_i,
  input  wire logic [3:0]  key_scan_inputs_i,
  input  wire logic        wdt_overflow_i,
  input  wire logic        sounder_src_i,
  input  wire logic        panel_clear_src_i,
  input  wire logic        panel_pump_src_i,
  input  wire logic [5:0]  converter_src_i,
  input  wire logic [15:0] key_scan_src_i,
  output logic             core_reset_o,
  output logic             pc_load_o,
  output logic      [11:0] pc_reset_addr_o,
  output logic      [10:0] start_condition_flags_o,
  output logic      [30:0] ctrl_flags_o,
  output logic      [27:0] periph_cfg_o,
  output logic             sounder_out_o,
  output logic             sounder_out_inv_o,
  output logic             panel_clear_out_o,
  output logic             panel_pump_out_o,
  output logic      [5:0]  converter_outputs_o,
  output logic      [15:0] key_scan_outputs_o,
  output logic             lcd_all_off_o,
  output logic             divider_clear_o,
  output logic             watchdog_run_o,
  output logic             watchdog_enable_flag_o
);

  localparam int LEN = SHORT_SEL ? reset_seq_pkg::SHORT_CYCLES
                                 : LONG_CYCLES;

  typedef struct packed {
    reset_seq_pkg::seq_state_t st;
    logic                      wd_cause;
    logic                      watchdog_enable_flag;
    logic [9:0]                s1;
    logic [9:0]                s2;
    logic [9:0]                s3;
    logic [9:0]                f;
    logic [9:0]                fp;
    logic                      combo_p;
    reset_seq_pkg::flags_t     flg;
    logic [10:0]               start_condition_flags;
    reset_seq_pkg::periph_t    per;
    logic                      snd;
    logic                      snd_n;
    logic                      clr;
    logic                      pump;
    logic [5:0]                conv;
    logic [15:0]               scan;
    logic                      ack;
    logic [31:0]               dat;
  } seq_regs_t;

  seq_regs_t r_reg;
  seq_regs_t r_next;
  interval_if cif ();

  logic combo;
  logic por_ev;
  logic pin_ev;
  logic key_ev;
  logic hold;
  logic ev;
  logic wd_only;
  logic wr_go;
  logic in_rst;

  ////////////////////////////////////////////////////////////////////////
  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // all selected inputs high together
  function automatic logic all_high(input logic [3:0] v,
                                    input logic [3:0] m);
    return (|m) && (&(v | ~m));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // interval counter
  interval_counter #(
    .LEN (LEN)
  ) u_cnt (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cif   (cif.cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // source decode from filtered inputs, watchdog overflow taken directly
  always_comb begin
    combo  = all_high(r_reg.f[5:2], KEY_PORT_MASK)
          || all_high(r_reg.f[9:6], KEY_SCAN_MASK);
    por_ev = POR_EN && r_reg.f[0] && !r_reg.fp[0];
    pin_ev = PIN_PULSE && !r_reg.f[1] && r_reg.fp[1];
    key_ev = r_reg.combo_p && !combo;
    hold   = (!PIN_PULSE && !r_reg.f[1]) || combo;
    ev     = por_ev || pin_ev || key_ev || wdt_overflow_i;
    wd_only = wdt_overflow_i && !(hold || por_ev || pin_ev || key_ev);
    wr_go  = wb_cyc_i && wb_stb_i && wb_we_i && r_reg.ack;
  end

  // counter control
  assign cif.abort = hold;
  assign cif.start = !hold && (ev || r_reg.st == reset_seq_pkg::ST_HOLD);

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_next = r_reg;
    // three-stage synchroniser, change taken once stages agree
    r_next.s1 = {key_scan_inputs_i, key_port_i, reset_pin_n_i, por_i};
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    for (int i = 0; i < reset_seq_pkg::NSYNC; i++) begin
      if (r_reg.s2[i] == r_reg.s3[i]) begin
        r_next.f[i] = r_reg.s3[i];
      end
    end
    r_next.fp      = r_reg.f;
    r_next.combo_p = combo;
    // sequencer
    if (hold) begin
      r_next.st = reset_seq_pkg::ST_HOLD;
    end else if (cif.start) begin
      r_next.st = reset_seq_pkg::ST_COUNT;
    end else if (r_reg.st == reset_seq_pkg::ST_COUNT && cif.done) begin
      r_next.st = reset_seq_pkg::ST_RUN;
    end
    // watchdog cause and enable flag
    if (hold || (ev && !wd_only)) begin
      r_next.wd_cause = 1'b0;
      r_next.watchdog_enable_flag      = 1'b0;
    end else if (wd_only) begin
      r_next.wd_cause = 1'b1;
    end
    // bus slave
    r_next.ack = wb_cyc_i && wb_stb_i && !r_reg.ack;
    if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
      case (wb_adr_i)
        reset_seq_pkg::ADR_STATUS:
          r_next.dat = {27'h0000000, combo, r_reg.watchdog_enable_flag, r_reg.wd_cause,
                        cif.busy, r_reg.st != reset_seq_pkg::ST_RUN};
        reset_seq_pkg::ADR_WDOG:
          r_next.dat = {31'h00000000, r_reg.watchdog_enable_flag};
        reset_seq_pkg::ADR_FLAGS:
          r_next.dat = {1'h0, r_reg.flg};
        reset_seq_pkg::ADR_START:
          r_next.dat = {21'h000000, r_reg.start_condition_flags};
        reset_seq_pkg::ADR_PERIPH:
          r_next.dat = {4'h0, r_reg.per};
        default:
          r_next.dat = 32'h00000000;
      endcase
    end
    in_rst = r_next.st != reset_seq_pkg::ST_RUN;
    if (wr_go && !in_rst) begin
      case (wb_adr_i)
        reset_seq_pkg::ADR_WDOG: begin
          if (wb_sel_i[0] && wb_dat_i[reset_seq_pkg::WDOG_STOP_BIT]) begin
            r_next.watchdog_enable_flag = 1'b0;
          end else if (wb_sel_i[0] &&
                       wb_dat_i[reset_seq_pkg::WDOG_START_BIT]) begin
            r_next.watchdog_enable_flag = 1'b1;
          end
        end
        reset_seq_pkg::ADR_FLAGS:
          r_next.flg = 31'(merge({1'h0, r_reg.flg}, wb_dat_i, wb_sel_i));
        reset_seq_pkg::ADR_START:
          r_next.start_condition_flags = 11'(merge({21'h0, r_reg.start_condition_flags}, wb_dat_i, wb_sel_i));
        reset_seq_pkg::ADR_PERIPH:
          r_next.per = 28'(merge({4'h0, r_reg.per}, wb_dat_i, wb_sel_i));
        default: begin
        end
      endcase
    end
    // forced initial state while in reset
    if (in_rst) begin
      r_next.flg = reset_seq_pkg::FLAGS_RST;
      r_next.start_condition_flags = reset_seq_pkg::START_RST;
      r_next.per = reset_seq_pkg::PERIPH_RST;
    end
    // pin drivers
    r_next.snd   = !in_rst && sounder_src_i;
    r_next.snd_n = !in_rst && !sounder_src_i;
    r_next.clr   = !in_rst && panel_clear_src_i;
    r_next.pump  = !in_rst && panel_pump_src_i;
    r_next.conv  = in_rst ? 6'h00 : converter_src_i;
    r_next.scan  = in_rst ? 16'hFFFF : key_scan_src_i;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg       <= '0;
      r_reg.st    <= reset_seq_pkg::ST_HOLD;
      r_reg.s1    <= reset_seq_pkg::SYNC_RST;
      r_reg.s2    <= reset_seq_pkg::SYNC_RST;
      r_reg.s3    <= reset_seq_pkg::SYNC_RST;
      r_reg.f     <= reset_seq_pkg::SYNC_RST;
      r_reg.fp    <= reset_seq_pkg::SYNC_RST;
      r_reg.flg   <= reset_seq_pkg::FLAGS_RST;
      r_reg.per   <= reset_seq_pkg::PERIPH_RST;
      r_reg.scan  <= 16'hFFFF;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign core_reset_o            = r_reg.st != reset_seq_pkg::ST_RUN;
  assign pc_load_o               = core_reset_o;
  assign pc_reset_addr_o         = reset_seq_pkg::PC_RESET_ADDR;
  assign start_condition_flags_o = r_reg.start_condition_flags;
  assign ctrl_flags_o            = r_reg.flg;
  assign periph_cfg_o            = r_reg.per;
  assign sounder_out_o           = r_reg.snd;
  assign sounder_out_inv_o       = r_reg.snd_n;
  assign panel_clear_out_o       = r_reg.clr;
  assign panel_pump_out_o        = r_reg.pump;
  assign converter_outputs_o     = r_reg.conv;
  assign key_scan_outputs_o      = r_reg.scan;
  assign lcd_all_off_o           = core_reset_o;
  assign divider_clear_o         = core_reset_o && !r_reg.wd_cause;
  assign watchdog_run_o          = r_reg.watchdog_enable_flag &&
                                   (!core_reset_o || r_reg.wd_cause);
  assign watchdog_enable_flag_o  = r_reg.watchdog_enable_flag;
  assign wb_ack_o                = r_reg.ack;
  assign wb_dat_o                = r_reg.dat;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_WDT_ENTER: assert property (
    wdt_overflow_i |=> core_reset_o)
    else $error("watchdog overflow did not reset");
  AST_PC_ZERO: assert property (
    core_reset_o |-> pc_load_o && pc_reset_addr_o == 12'h000)
    else $error("pc not forced to zero");
  AST_FLAGS: assert property (
    core_reset_o |-> ctrl_flags_o == 31'h40000000 &&
                     start_condition_flags_o == 11'h000)
    else $error("flags not at initial values");
  AST_PINS_LOW: assert property (
    core_reset_o ##1 core_reset_o |-> !sounder_out_o &&
      !sounder_out_inv_o && !panel_clear_out_o && !panel_pump_out_o)
    else $error("sounder or panel output not low");
  AST_CFG: assert property (
    core_reset_o |-> periph_cfg_o == reset_seq_pkg::PERIPH_RST)
    else $error("peripheral config not at initial values");
  AST_CONV_SCAN: assert property (
    core_reset_o ##1 core_reset_o |-> converter_outputs_o == 6'h00 &&
      key_scan_outputs_o == 16'hFFFF)
    else $error("converter or scan outputs wrong");
  AST_HOLD: assert property (
    hold |=> !cif.busy && core_reset_o)
    else $error("counter ran while held");
  AST_START: assert property (
    ev && !hold |=> cif.busy && core_reset_o)
    else $error("event did not start interval");
  AST_RELEASE: assert property (
    $fell(core_reset_o) |-> $past(cif.done))
    else $error("released without interval end");
  AST_WDF_CLR: assert property (
    core_reset_o && !r_reg.wd_cause |-> !watchdog_enable_flag_o)
    else $error("watchdog flag kept on non-watchdog reset");
  AST_WD_KEEP: assert property (
    wd_only && r_reg.watchdog_enable_flag |=> watchdog_run_o && !divider_clear_o)
    else $error("watchdog reset stopped watchdog or cleared divider");
  AST_SYNC: assert property (
    $changed(r_reg.f[1]) |-> $past(r_reg.s2[1] == r_reg.s3[1]))
    else $error("pin change taken before stages agreed");

  COV_WDT: cover property (wd_only ##1 core_reset_o ##[1:20] cif.busy);
  COV_LEVEL: cover property (hold ##1 !hold ##1 cif.busy);
  COV_DONE: cover property (cif.done ##1 !core_reset_o);
  COV_KEY: cover property (key_ev ##1 cif.busy);

endmodule // mcu_reset_sequencer
`default_nettype wire

// >>> pkg/reset_seq_pkg.sv
// Purpose: shared constants and types for the reset sequencer
// Assumes: base clock is the pre-divider input clock
// Notes:   register fields are packed structs, low bit last
package reset_seq_pkg;

  // interval lengths in base clock cycles
  localparam int SHORT_CYCLES    = 2048;
  localparam int LONG_CYCLES_DEF = 16384;
  localparam int CNT_W           = 15;

  // synchroniser lanes: 0 por, 1 pin, 5:2 port keys, 9:6 scan keys
  localparam int        NSYNC    = 10;
  localparam logic [9:0] SYNC_RST = 10'h002;

  // restart address of the core
  localparam logic [11:0] PC_RESET_ADDR = 12'h000;

  // register byte offsets
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_WDOG   = 8'h04;
  localparam logic [7:0] ADR_FLAGS  = 8'h08;
  localparam logic [7:0] ADR_START  = 8'h0C;
  localparam logic [7:0] ADR_PERIPH = 8'h10;

  // watchdog control bits
  localparam int WDOG_START_BIT = 0;
  localparam int WDOG_STOP_BIT  = 1;

  // selector encodings
  localparam logic [1:0] DUTY_QUARTER = 2'h0;
  localparam logic [1:0] DEB_STAGE10  = 2'h2;
  localparam logic       SRC_BASE     = 1'h0;
  localparam logic       SRC_STAGE8   = 1'h0;
  localparam logic       CLK_SLOW_XT  = 1'h0;

  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_COUNT} seq_state_t;

  typedef struct packed {
    logic       backup_mode_flag;
    logic [7:0] irq_enable_flags;
    logic [5:0] halt_release_enable_flags;
    logic [7:0] halt_request_flags;
    logic [4:0] switch_enable_flags;
    logic [2:0] stop_release_enable_flags;
  } flags_t;

  typedef struct packed {
    logic [4:0] port_out_en;
    logic [4:0] pull_low_en;
    logic       sysclk_fast;
    logic [2:0] timer_run;
    logic       scan_run;
    logic       conv_run;
    logic       fgen_run;
    logic [1:0] fgen_duty;
    logic       fgen_src;
    logic [1:0] clear_duty;
    logic       clear_src;
    logic [1:0] pump_duty;
    logic       pump_src;
    logic [1:0] deb_sel;
  } periph_t;

  localparam flags_t FLAGS_RST = '{backup_mode_flag: 1'h1, default: '0};
  localparam logic [10:0] START_RST = 11'h000;
  localparam periph_t PERIPH_RST = '{
    port_out_en: 5'h00, pull_low_en: 5'h1F, sysclk_fast: CLK_SLOW_XT,
    timer_run: 3'h0, scan_run: 1'h0, conv_run: 1'h0, fgen_run: 1'h0,
    fgen_duty: DUTY_QUARTER, fgen_src: SRC_BASE,
    clear_duty: DUTY_QUARTER, clear_src: SRC_STAGE8,
    pump_duty: DUTY_QUARTER, pump_src: SRC_BASE, deb_sel: DEB_STAGE10};

endpackage

// >>> pkg/interval_if.sv
// Purpose: link between sequencer and interval counter
// Assumes: one clock domain
// Notes:   start and done are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface interval_if;
  logic start;
  logic abort;
  logic busy;
  logic done;
  modport ctl (output start, output abort, input busy, input done);
  modport cnt (input start, input abort, output busy, output done);
endinterface // interval_if
`default_nettype wire

// >>> verilog/interval_counter.sv
// Purpose: counts the reset interval in base clock cycles
// Assumes: LEN fits in CNT_W bits
// Notes:   start restarts, abort idles, done pulses after LEN cycles
`timescale 1ns/10ps
`default_nettype none
module interval_counter #(
  parameter int LEN = reset_seq_pkg::LONG_CYCLES_DEF
) (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  interval_if.cnt    cif
);

  localparam logic [reset_seq_pkg::CNT_W-1:0] LAST =
    reset_seq_pkg::CNT_W'(LEN - 1);

  typedef struct packed {
    logic [reset_seq_pkg::CNT_W-1:0] cnt;
    logic                            busy;
    logic                            done;
  } cnt_state_t;

  cnt_state_t r_reg;
  cnt_state_t r_next;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (cif.abort) begin
      r_next.busy = 1'b0;
      r_next.cnt  = '0;
    end else if (cif.start) begin
      r_next.busy = 1'b1;
      r_next.cnt  = '0;
    end else if (r_reg.busy) begin
      if (r_reg.cnt == LAST) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cif.busy = r_reg.busy;
  assign cif.done = r_reg.done;

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_CNT_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    cif.done |-> $past(r_reg.cnt) == LAST && $past(r_reg.busy))
    else $error("interval ended at wrong count");

endmodule // interval_counter
`default_nettype wire

// >>> dv/far_end.sv
// Purpose: model of the far side: power detect, reset pin, keys, watchdog
// Assumes: changes only right after rising edges of clk_i
// Notes:   pin idles high through its pull-up, keys idle low
`timescale 1ns/10ps
`default_nettype none
module far_end (
  input  wire logic       clk_i,
  output logic            por_o,
  output logic            pin_n_o,
  output logic      [3:0] keys_o,
  output logic            wdt_o
);
  // idle levels at time zero
  initial begin
    por_o   = 1'b0;
    pin_n_o = 1'b1;
    keys_o  = 4'h0;
    wdt_o   = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // assert one source for n cycles: 0 power, 1 pin, 2 keys, 3 watchdog
  task automatic act(input int which, input int n);
    @(posedge clk_i);
    case (which)
      0: por_o <= 1'b1;
      1: pin_n_o <= 1'b0;
      2: keys_o <= 4'hF;
      default: wdt_o <= 1'b1;
    endcase
    repeat (n) @(posedge clk_i);
    por_o   <= 1'b0;
    pin_n_o <= 1'b1;
    keys_o  <= 4'h0;
    wdt_o   <= 1'b0;
  endtask
endmodule // far_end
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: register and reset-source tests of the reset sequencer
// Assumes: interval shortened to LEN cycles, level pin, scan-key combo
// Notes:   bus tasks are classic single-cycle transfers
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int LEN = 16;
  logic        clk_i, rst_i, cyc, stb, we, ack, por, pin_n, wdt;
  logic [7:0]  adr;
  logic [3:0]  sel, keys;
  logic [31:0] wdat, rdat, q;
  logic [15:0] pat;
  logic        cr, pcl, snd, sndi, pclr, ppmp, lcd, dclr, wrun, watchdog_enable_flag;
  logic [11:0] pca;
  logic [10:0] start_condition_flags;
  logic [30:0] flg;
  logic [27:0] per;
  logic [5:0]  conv;
  logic [15:0] kso;
  int          bad_count, checked, n, k;

  mcu_reset_sequencer #(.LONG_CYCLES(LEN)) DUT (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .por_i(por), .reset_pin_n_i(pin_n),
    .key_port_i(4'h0), .key_scan_inputs_i(keys), .wdt_overflow_i(wdt),
    .sounder_src_i(pat[0]), .panel_clear_src_i(pat[1]),
    .panel_pump_src_i(pat[2]), .converter_src_i(pat[8:3]),
    .key_scan_src_i(pat), .core_reset_o(cr), .pc_load_o(pcl),
    .pc_reset_addr_o(pca), .start_condition_flags_o(start_condition_flags),
    .ctrl_flags_o(flg), .periph_cfg_o(per), .sounder_out_o(snd),
    .sounder_out_inv_o(sndi), .panel_clear_out_o(pclr),
    .panel_pump_out_o(ppmp), .converter_outputs_o(conv),
    .key_scan_outputs_o(kso), .lcd_all_off_o(lcd),
    .divider_clear_o(dclr), .watchdog_run_o(wrun),
    .watchdog_enable_flag_o(watchdog_enable_flag));

  far_end far (.clk_i(clk_i), .por_o(por), .pin_n_o(pin_n),
    .keys_o(keys), .wdt_o(wdt));

  //////////////////////////////////////////////////////////////////////////
  // verdict and comparison
  task automatic end_of_test;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one bus transfer, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int i;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (i >= 50) begin
      bad_count++;
      end_of_test();
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // count cycles spent in reset, from first high to fall
  task automatic measure(output int cnt);
    int i;
    i = 0;
    cnt = 0;
    while ((cnt == 0 || cr === 1'b1) && i < 400) begin
      @(posedge clk_i);
      i++;
      if (cr === 1'b1) cnt++;
    end
    if (i >= 400) begin
      bad_count++;
      end_of_test();
    end
  endtask

  // state forced while reset is held; wd marks a watchdog cause
  task automatic in_reset(input logic wd);
    chk(32'(cr), 32'h1);
    chk(32'({pcl, pca}), 32'h1000);
    chk(32'(flg), 32'(reset_seq_pkg::FLAGS_RST));
    chk(32'(start_condition_flags), 32'h0);
    chk(32'({snd, sndi, pclr, ppmp}), 32'h0);
    chk(32'(per), 32'(reset_seq_pkg::PERIPH_RST));
    chk(32'(conv), 32'h0);
    chk(32'({lcd, kso}), 32'h1FFFF);
    chk(32'({watchdog_enable_flag, wrun, dclr}), 32'({wd, wd, ~wd}));
  endtask

  //////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // main sequence
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wdat} = '0;
    sel = 4'hF;
    pat = 16'hA5C3;
    bad_count = 0;
    checked = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    measure(n);
    chk(32'(n >= LEN && n <= LEN + 8), 32'h1);
    wb(1'b0, reset_seq_pkg::ADR_FLAGS, 32'h0, q);
    chk(q, 32'h4000_0000);
    wb(1'b0, reset_seq_pkg::ADR_PERIPH, 32'h0, q);
    chk(q, 32'(reset_seq_pkg::PERIPH_RST));
    wb(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0);
    chk(32'({snd, sndi, kso}), 32'h2A5C3);
    $display("test post-reset done");
    // watchdog, keys, pin, power: each after arming the watchdog
    for (k = 3; k >= 0; k--) begin
      wb(1'b1, reset_seq_pkg::ADR_FLAGS, 32'h3FFF_FFFF, q);
      wb(1'b0, reset_seq_pkg::ADR_FLAGS, 32'h0, q);
      chk(q, 32'h3FFF_FFFF);
      wb(1'b1, reset_seq_pkg::ADR_WDOG, 32'h1, q);
      wb(1'b0, reset_seq_pkg::ADR_WDOG, 32'h0, q);
      chk(q, 32'h1);
      // power held past the three-stage filter, watchdog is one pulse
      fork
        far.act(k, (k == 1 || k == 2) ? 40 : (k == 0 ? 8 : 1));
        measure(n);
        begin
          repeat (12) @(posedge clk_i);
          in_reset(k == 3);
        end
      join
      if (k == 1 || k == 2) begin
        chk(32'(n >= LEN + 40 && n <= LEN + 48), 32'h1);
      end else begin
        chk(32'(n >= LEN && n <= LEN + 8), 32'h1);
      end
      wb(1'b0, reset_seq_pkg::ADR_STATUS, 32'h0, q);
      chk(32'(q[3]), 32'(k == 3));
      $display("test source %0d done", k);
    end
    // stop command wins over start in one write
    wb(1'b1, reset_seq_pkg::ADR_WDOG, 32'h1, q);
    wb(1'b1, reset_seq_pkg::ADR_WDOG, 32'h3, q);
    wb(1'b0, reset_seq_pkg::ADR_WDOG, 32'h0, q);
    chk(q, 32'h0);
    $display("test watchdog stop done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
